/* File: rtl/cache_port_defs.svh */
// constants of the processor bus port
`ifndef CACHE_PORT_DEFS_SVH
`define CACHE_PORT_DEFS_SVH

`define ADDR_W        36
`define SIZE_W        2
`define IRQ_W         4
`define IRQ_NONE      4'h0
`define IRQ_NMI       4'hf
`define ADDR_INV_BIT  20
`define WCNT_W        4
// acknowledge pins {fault_n, ready_n, retry_n}
`define ACK_NONE      3'h7
`define ACK_RETRY     3'h6
`define ACK_DONE      3'h5
`define ACK_UNDEF     3'h4
`define ACK_BUSERR    3'h3
`define ACK_TIMEOUT   3'h2

`endif

/* File: rtl/cache_port_pkg.sv */
// types of the processor bus port
package cache_port_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_WITHDRAW,
        ST_STROBE
    } port_state_t;

    typedef enum logic [2:0] {
        XK_NONE,
        XK_READ,
        XK_WRITE,
        XK_ATOMIC,
        XK_DEMAP_DONE,
        XK_DEMAP_REQ
    } xact_kind_t;

    typedef enum logic [2:0] {
        BC_RETRY,
        BC_DONE,
        BC_UNDEF,
        BC_BUSERR,
        BC_TIMEOUT
    } beat_code_t;

    typedef struct packed {
        xact_kind_t  kind;
        logic [35:0] addr;
        logic        cacheable;
        logic        ctrl_space;
        logic [1:0]  size;
        logic        privileged;
        logic        burst;
    } cmd_t;

    typedef struct packed {
        logic [35:0] addr;
        logic        demap;
    } launch_t;

    typedef struct packed {
        port_state_t st;
        cmd_t        cmd;
        logic        burst;
        logic [1:0]  resample;
        logic [2:0]  ack_n;
        logic        ack_rd;
        logic        cmd_valid;
        logic [3:0]  irq;
        logic        err_n;
        logic        rst_out_n;
        logic        sel_caught;
        logic        sel;
        logic        a20_n;
        logic        rgnt_n;
        logic        wgnt_n;
        logic        strobe_n;
        logic [35:0] laddr;
        logic        ldemap_n;
        logic        lwr_n;
        logic        oe_n;
    } port_regs_t;

endpackage : cache_port_pkg

/* File: rtl/cache_proc_port.sv */
// processor-side bus port of the external cache controller
// Summary of operation
// - after the final beat of a burst no further read or write ready.
// - error output low on internal error or processor error, else high.
// - bus master pulses command strobe low one cycle to open each access.
// - with both grants high the port strobes invalidate or demap command words.
// - low control-space qualifier targets tags, cache or registers, decoded as such; a strobe taken in ST_WITHDRAW keeps the previous ctrl_space.
// - demap line with strobe marks demap; output requests entry removal.
// - processor error input low resets the port's own state.
// - interrupt level shows highest pending; 0 none, 15 nonmaskable.
// - atomic cycle excludes every other transaction while it runs.
// - acknowledges use fault, ready, retry codes; the reserved undefined code (ready and retry low) is driven for BC_UNDEF beats.
// - port drives SRAM output enable low and watches it to avoid collisions.
// - pending output low while any write of this processor is incomplete.
// - read decode: with demap done, plain read, with atomic and write atomic.
// - inverted address bit 20 is driven for two-megabyte caches.
// - read and write grants low allow the processor, high deny it.
// - on write ready the data is taken and the next address may follow.
`timescale 1ns/100ps
`include "cache_port_defs.svh"

module cache_proc_port #(
    parameter int ADDR_W = `ADDR_W
) (
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    // processor bus, command inputs
    input  wire logic                        cmd_strobe_in_n,
    input  wire logic [ADDR_W-1:0]           addr_in,
    input  wire logic                        burst,
    input  wire logic                        cacheable_qual_n,
    input  wire logic                        control_space_sel_n,
    input  wire logic                        demap_in_n,
    input  wire logic                        atomic_swap_n,
    input  wire logic [`SIZE_W-1:0]          size,
    input  wire logic                        privileged_access_n,
    input  wire logic                        rd_n,
    input  wire logic                        wr_in_n,
    input  wire logic                        error_in_n,
    input  wire logic                        sram_oe_in_n,
    input  wire logic                        system_reset_in_n,
    input  wire logic                        sysbus_select,
    // processor bus, driven by the port
    output logic                             cmd_strobe_out_n,
    output logic                             cmd_strobe_oe,
    output logic [ADDR_W-1:0]                addr_out,
    output logic                             addr_oe,
    output logic                             demap_out_n,
    output logic                             demap_oe,
    output logic                             wr_out_n,
    output logic                             wr_oe,
    output logic                             read_grant_n,
    output logic                             write_grant_n,
    output logic                             read_ack_n,
    output logic                             write_ack_n,
    output logic                             bus_fault_ack_n,
    output logic                             retry_n,
    output logic                             error_n,
    output logic [`IRQ_W-1:0]                irq_level,
    output logic                             write_outstanding_n,
    output logic                             sram_oe_out_n,
    output logic                             sram_oe_en,
    output logic                             addr20_inv_n,
    output logic                             proc_reset_n,
    // core side, commands and beats
    output logic                             cmd_valid,
    output cache_port_pkg::cmd_t             cmd,
    input  wire logic                        beat_valid,
    input  wire cache_port_pkg::beat_code_t  beat_code,
    output logic                             beat_ready,
    input  wire logic                        sram_read_req,
    // core side, invalidate and demap launch
    input  wire logic                        inv_valid,
    input  wire cache_port_pkg::launch_t     inv,
    output logic                             inv_ready,
    // core side, control and status
    input  wire logic                        allow_read,
    input  wire logic                        allow_write,
    input  wire logic                        internal_error,
    input  wire logic                        write_done,
    input  wire logic [15:1]                 irq_pending,
    output logic                             packet_mode
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] ack_pins(input cache_port_pkg::beat_code_t c);
        case (c)
            cache_port_pkg::BC_RETRY:   ack_pins = `ACK_RETRY;
            cache_port_pkg::BC_DONE:    ack_pins = `ACK_DONE;
            cache_port_pkg::BC_UNDEF:   ack_pins = `ACK_UNDEF;
            cache_port_pkg::BC_BUSERR:  ack_pins = `ACK_BUSERR;
            cache_port_pkg::BC_TIMEOUT: ack_pins = `ACK_TIMEOUT;
            default:                    ack_pins = `ACK_NONE;
        endcase
    endfunction : ack_pins

    function automatic logic [3:0] irq_encode(input logic [15:1] p);
        irq_encode = `IRQ_NONE;
        for (int i = 1; i <= 15; i++) begin
            if (p[i]) begin
                irq_encode = 4'(i);
            end
        end
    endfunction : irq_encode

    function automatic cache_port_pkg::xact_kind_t decode_kind(
        input logic r_n, input logic w_n, input logic d_n, input logic a_n);
        if (!r_n && !w_n && !a_n) begin
            decode_kind = cache_port_pkg::XK_ATOMIC;
        end else if (!r_n && !d_n) begin
            decode_kind = cache_port_pkg::XK_DEMAP_DONE;
        end else if (!r_n) begin
            decode_kind = cache_port_pkg::XK_READ;
        end else if (!w_n && !d_n) begin
            decode_kind = cache_port_pkg::XK_DEMAP_REQ;
        end else if (!w_n) begin
            decode_kind = cache_port_pkg::XK_WRITE;
        end else begin
            decode_kind = cache_port_pkg::XK_NONE;
        end
    endfunction : decode_kind

    localparam cache_port_pkg::port_regs_t RST_S = '{
        st: cache_port_pkg::ST_IDLE, cmd: '0, burst: 1'b0, resample: 2'h0,
        ack_n: `ACK_NONE, ack_rd: 1'b0, cmd_valid: 1'b0, irq: `IRQ_NONE,
        err_n: 1'b1, rst_out_n: 1'b0, sel_caught: 1'b0, sel: 1'b1, a20_n: 1'b1,
        rgnt_n: 1'b1, wgnt_n: 1'b1, strobe_n: 1'b1, laddr: '0, ldemap_n: 1'b1,
        lwr_n: 1'b1, oe_n: 1'b1};

    cache_port_pkg::port_regs_t s_q;
    cache_port_pkg::port_regs_t s_d;
    logic                       beat_take;
    logic                       is_write;
    logic                       is_read;
    logic                       wr_busy;

    assign is_write  = (s_q.cmd.kind == cache_port_pkg::XK_WRITE) ||
                       (s_q.cmd.kind == cache_port_pkg::XK_ATOMIC);
    assign is_read   = (s_q.cmd.kind == cache_port_pkg::XK_READ) ||
                       (s_q.cmd.kind == cache_port_pkg::XK_ATOMIC);
    assign beat_ready = (s_q.st == cache_port_pkg::ST_ACTIVE) && (s_q.resample == 2'h0);
    assign beat_take  = beat_ready && beat_valid;
    assign inv_ready  = (s_q.st == cache_port_pkg::ST_STROBE);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d           = s_q;
        s_d.cmd_valid = 1'b0;
        s_d.ack_n     = `ACK_NONE;
        s_d.strobe_n  = 1'b1;
        s_d.resample  = {s_q.resample[0], 1'b0};
        s_d.irq       = irq_encode(irq_pending);
        s_d.err_n     = !(internal_error || !error_in_n);
        s_d.rst_out_n = system_reset_in_n;
        s_d.rgnt_n    = !allow_read;
        s_d.wgnt_n    = !allow_write;
        if (!s_q.sel_caught) begin
            s_d.sel_caught = 1'b1;
            s_d.sel        = sysbus_select;
        end
        // own the shared enable only while nobody else holds it low
        s_d.oe_n = !(sram_read_req && (s_q.st == cache_port_pkg::ST_ACTIVE) && is_read &&
                     (!s_q.oe_n || sram_oe_in_n));
        case (s_q.st)
            cache_port_pkg::ST_IDLE: begin
                if (!cmd_strobe_in_n) begin
                    s_d.cmd.kind       = decode_kind(rd_n, wr_in_n, demap_in_n,
                                                     atomic_swap_n);
                    s_d.cmd.addr       = addr_in;
                    s_d.cmd.cacheable  = !cacheable_qual_n;
                    s_d.cmd.ctrl_space = !control_space_sel_n;
                    s_d.cmd.size       = size;
                    s_d.cmd.privileged = !privileged_access_n;
                    s_d.cmd.burst      = burst;
                    s_d.burst          = burst;
                    s_d.a20_n          = !addr_in[`ADDR_INV_BIT];
                    s_d.cmd_valid      = 1'b1;
                    s_d.st             = cache_port_pkg::ST_ACTIVE;
                end else if (inv_valid) begin
                    s_d.laddr    = inv.addr;
                    s_d.ldemap_n = !inv.demap;
                    s_d.lwr_n    = inv.demap;
                    s_d.rgnt_n   = 1'b1;
                    s_d.wgnt_n   = 1'b1;
                    s_d.st       = cache_port_pkg::ST_WITHDRAW;
                end
            end
            cache_port_pkg::ST_ACTIVE: begin
                // new strobes and launches wait, atomic cycles included
                if (s_q.resample[1]) begin
                    s_d.burst = burst;
                end
                if (beat_take) begin
                    s_d.ack_n  = ack_pins(beat_code);
                    s_d.ack_rd = (s_q.cmd.kind != cache_port_pkg::XK_WRITE) &&
                                 (s_q.cmd.kind != cache_port_pkg::XK_DEMAP_REQ);
                    if (beat_code != cache_port_pkg::BC_DONE || !s_q.burst) begin
                        s_d.st = cache_port_pkg::ST_IDLE;
                    end else begin
                        s_d.resample = 2'h1;
                    end
                end
            end
            cache_port_pkg::ST_WITHDRAW: begin
                s_d.rgnt_n = 1'b1;
                s_d.wgnt_n = 1'b1;
                if (!cmd_strobe_in_n) begin
                    // processor strobed before seeing the withdrawal
                    s_d.cmd.kind  = decode_kind(rd_n, wr_in_n, demap_in_n, atomic_swap_n);
                    s_d.cmd.addr  = addr_in;
                    s_d.cmd.burst = burst;
                    s_d.burst     = burst;
                    s_d.a20_n     = !addr_in[`ADDR_INV_BIT];
                    s_d.cmd_valid = 1'b1;
                    s_d.st        = cache_port_pkg::ST_ACTIVE;
                end else begin
                    s_d.strobe_n = 1'b0;
                    s_d.st       = cache_port_pkg::ST_STROBE;
                end
            end
            cache_port_pkg::ST_STROBE: begin
                s_d.rgnt_n = 1'b1;
                s_d.wgnt_n = 1'b1;
                s_d.st     = cache_port_pkg::ST_IDLE;
            end
            default: begin
                s_d.st = cache_port_pkg::ST_IDLE;
            end
        endcase
        if (!error_in_n) begin
            s_d            = RST_S;
            s_d.err_n      = 1'b0;
            s_d.rst_out_n  = system_reset_in_n;
            s_d.sel_caught = s_q.sel_caught;
            s_d.sel        = s_q.sel;
            s_d.irq        = irq_encode(irq_pending);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= RST_S;
        end else begin
            s_q <= s_d;
        end
    end

    write_tracker #(
        .W (`WCNT_W)
    ) u_wtrack (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clr     (!error_in_n),
        .inc     (beat_take && is_write && beat_code == cache_port_pkg::BC_DONE),
        .dec     (write_done),
        .busy    (wr_busy)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign cmd_strobe_out_n    = s_q.strobe_n;
    assign cmd_strobe_oe       = !s_q.strobe_n;
    assign addr_out            = s_q.laddr;
    assign addr_oe             = !s_q.strobe_n;
    assign demap_out_n         = s_q.ldemap_n;
    assign demap_oe            = !s_q.strobe_n;
    assign wr_out_n            = s_q.lwr_n;
    assign wr_oe               = !s_q.strobe_n;
    assign read_grant_n        = s_q.rgnt_n;
    assign write_grant_n       = s_q.wgnt_n;
    assign bus_fault_ack_n     = s_q.ack_n[2];
    assign read_ack_n          = s_q.ack_rd ? s_q.ack_n[1] : 1'b1;
    assign write_ack_n         = s_q.ack_rd ? 1'b1 : s_q.ack_n[1];
    assign retry_n             = s_q.ack_n[0];
    assign error_n             = s_q.err_n;
    assign irq_level           = s_q.irq;
    assign write_outstanding_n = !(wr_busy || ((s_q.st == cache_port_pkg::ST_ACTIVE) &&
                                               is_write));
    assign sram_oe_out_n       = s_q.oe_n;
    assign sram_oe_en          = !s_q.oe_n;
    assign addr20_inv_n        = s_q.a20_n;
    assign proc_reset_n        = s_q.rst_out_n;
    assign cmd_valid           = s_q.cmd_valid;
    assign cmd                 = s_q.cmd;
    assign packet_mode         = !s_q.sel;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_burst_last_stop: assert property (beat_take && !s_q.burst && error_in_n
        |=> ##1 (read_ack_n && write_ack_n)) else $error("ready after final beat");
    a_error_merge: assert property ((internal_error || !error_in_n) |=> !error_n
        ) else $error("error output not asserted");
    a_error_clear: assert property (!internal_error && error_in_n |=> error_n
        ) else $error("error output stuck low");
    a_strobe_single: assert property (!cmd_strobe_out_n |=> cmd_strobe_out_n
        ) else $error("own strobe longer than one cycle");
    a_launch_grants: assert property (!cmd_strobe_out_n |-> read_grant_n &&
        write_grant_n && $past(read_grant_n)) else $error("launch while granted");
    a_soft_reset: assert property (!error_in_n |=> s_q.st == cache_port_pkg::ST_IDLE
        && write_outstanding_n) else $error("no internal reset");
    a_irq_level_nmi: assert property (irq_pending[15] |=> irq_level == `IRQ_NMI
        ) else $error("nonmaskable level missing");
    a_irq_level_none: assert property (irq_pending == '0 |=> irq_level == `IRQ_NONE
        ) else $error("phantom interrupt level");
    a_atomic_excl: assert property (s_q.st == cache_port_pkg::ST_ACTIVE &&
        s_q.cmd.kind == cache_port_pkg::XK_ATOMIC |-> !inv_ready && cmd_strobe_out_n)
        else $error("launch during atomic cycle");
    a_ack_reserved: assert property (!bus_fault_ack_n |-> read_ack_n && write_ack_n
        ) else $error("reserved acknowledge code");
    a_ack_done_time: assert property (beat_take && error_in_n &&
        beat_code == cache_port_pkg::BC_DONE |=> !(read_ack_n && write_ack_n) &&
        retry_n && bus_fault_ack_n) else $error("completion not acknowledged");
    a_write_pending: assert property (beat_take && is_write && error_in_n &&
        beat_code == cache_port_pkg::BC_DONE |=> !write_outstanding_n)
        else $error("pending not shown after write");
    a_addr20_inv: assert property (s_q.st == cache_port_pkg::ST_IDLE &&
        !cmd_strobe_in_n && error_in_n |=> addr20_inv_n == !$past(addr_in[20]))
        else $error("address bit 20 not inverted");

    c_burst_read: cover property (beat_take && s_q.burst &&
        s_q.cmd.kind == cache_port_pkg::XK_READ);
    c_launch: cover property (inv_ready && !demap_out_n);
    c_retry: cover property (!retry_n && read_ack_n && write_ack_n);

endmodule : cache_proc_port

/* File: rtl/write_tracker.sv */
// count of writes accepted but not yet completed downstream
`timescale 1ns/100ps
`include "cache_port_defs.svh"

module write_tracker #(
    parameter int W = `WCNT_W
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // events
    input  wire logic clr,
    input  wire logic inc,
    input  wire logic dec,
    // state
    output logic      busy
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } wtrack_t;

    wtrack_t s_q;
    wtrack_t s_d;

    always_comb begin
        s_d = s_q;
        if (clr) begin
            s_d.cnt = '0;
        end else if (inc && !dec && s_q.cnt != {W{1'b1}}) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (dec && !inc && s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = (s_q.cnt != '0);

endmodule : write_tracker

/* File: test/proc_model.sv */
// processor core model issuing single and burst accesses
`timescale 1ns/100ps
module proc_model (
    // bench control
    input  wire logic       clk_sys,
    input  wire logic       go,
    input  wire logic       wr,
    input  wire logic [1:0] beats,
    // processor bus
    input  wire logic       ack_n,
    output logic            strobe_n = 1'b1,
    output logic [35:0]     addr = 36'h0,
    output logic            burst = 1'b0,
    output logic            rd_n = 1'b1,
    output logic            wr_n = 1'b1
);
    int left;
    always begin
        @(posedge clk_sys);
        if (go) begin
            left = beats;
            @(negedge clk_sys);
            strobe_n = 1'b0;
            addr = 36'h0_0010_0000;
            rd_n = wr;
            wr_n = !wr;
            burst = (left > 1);
            @(negedge clk_sys);
            strobe_n = 1'b1;
            while (left > 0) begin
                @(negedge clk_sys);
                if (!ack_n) begin
                    left--;
                    addr = addr + 36'h8;
                    burst = (left > 1);
                end
            end
            rd_n = 1'b1;
            wr_n = 1'b1;
        end
    end
endmodule : proc_model

/* File: test/tb_top.sv */
// self-checking bench for the processor bus port
`timescale 1ns/100ps
module tb_top;
    logic clk_sys = 1'b0, rst_n = 1'b0, go = 1'b0, pwr = 1'b0, bv = 1'b0, iv = 1'b0;
    logic alw = 1'b1, ierr = 1'b0, perr_n = 1'b1, sr_n = 1'b1, wdone = 1'b0, cq_n = 1'b0;
    logic [1:0] beats = 2'h1, sz = 2'h3;
    logic [15:1] irqp = 15'h0;
    logic [2:0] last_ack = 3'h7;
    logic strobe_n, burst, rd_n, wr_n, rda_n, wra_n, flt_n, rty_n, err_n, wo_n;
    logic rg_n, wg_n, br, ir, so_n, soe, swr_n, a20_n, prst_n, pm, dmo_n;
    logic [35:0] addr, lad;
    logic [3:0] irl;
    int n_errors = 0, comparisons = 0, nrd = 0, nwr = 0, k0;
    cache_port_pkg::beat_code_t bc = cache_port_pkg::BC_DONE;
    cache_port_pkg::cmd_t cmd;
    proc_model u_proc (.clk_sys(clk_sys), .go(go), .wr(pwr), .beats(beats),
        .ack_n(rda_n & wra_n & rty_n & flt_n), .strobe_n(strobe_n), .addr(addr),
        .burst(burst), .rd_n(rd_n), .wr_n(wr_n));
    cache_proc_port u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_strobe_in_n(strobe_n),
        .addr_in(addr), .burst(burst), .cacheable_qual_n(cq_n), .control_space_sel_n(cq_n),
        .demap_in_n(1'b1), .atomic_swap_n(1'b1), .size(sz), .privileged_access_n(cq_n),
        .rd_n(rd_n), .wr_in_n(wr_n), .error_in_n(perr_n), .sram_oe_in_n(1'b1),
        .system_reset_in_n(sr_n), .sysbus_select(1'b0), .cmd_strobe_out_n(so_n),
        .cmd_strobe_oe(soe), .addr_out(lad), .addr_oe(), .demap_out_n(dmo_n), .demap_oe(),
        .wr_out_n(swr_n), .wr_oe(), .read_grant_n(rg_n), .write_grant_n(wg_n),
        .read_ack_n(rda_n), .write_ack_n(wra_n), .bus_fault_ack_n(flt_n), .retry_n(rty_n),
        .error_n(err_n), .irq_level(irl), .write_outstanding_n(wo_n), .sram_oe_out_n(),
        .sram_oe_en(), .addr20_inv_n(a20_n), .proc_reset_n(prst_n), .cmd_valid(),
        .cmd(cmd), .beat_valid(bv), .beat_code(bc), .beat_ready(br), .sram_read_req(1'b0),
        .inv_valid(iv), .inv({36'h0_0000_0040, 1'b0}), .inv_ready(ir), .allow_read(alw),
        .allow_write(alw), .internal_error(ierr), .write_done(wdone), .irq_pending(irqp),
        .packet_mode(pm));
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (rda_n === 1'b0) nrd <= nrd + 1;
        if (wra_n === 1'b0) nwr <= nwr + 1;
        if ({flt_n, rda_n, wra_n, rty_n} !== 4'hf) last_ack <= {flt_n, rda_n & wra_n, rty_n};
    end
    task automatic wrap_up();
        if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    // one processor access, every beat answered with the same code
    task automatic xfer(input logic w, input logic [1:0] n, input cache_port_pkg::beat_code_t c);
        int k;
        tick(1);
        pwr = w;
        beats = n;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        for (int b = 0; b < n; b++) begin
            k = 0;
            while (br !== 1'b1 && k < 20) begin
                tick(1);
                k++;
            end
            bv = 1'b1;
            bc = c;
            tick(1);
            bv = 1'b0;
            tick(1);
        end
        tick(8);
    endtask : xfer
    initial begin
        tick(800);
        n_errors++;
        wrap_up();
    end
    initial begin
        tick(16);
        chk("grant in reset", 1, rg_n);
        chk("proc reset", 0, prst_n);
        rst_n = 1'b1;
        tick(3);
        chk("packet mode", 1, pm);
        chk("read grant", 0, rg_n);
        chk("write grant", 0, wg_n);
        k0 = nrd;
        xfer(1'b0, 2'h3, cache_port_pkg::BC_DONE);
        chk("burst acks", 3, nrd - k0);
        chk("kind", cache_port_pkg::XK_READ, cmd.kind);
        chk("addr20 inv", 0, a20_n);
        for (int i = 0; i < 5; i++) begin
            sz = i[1:0];
            cq_n = i[0];
            xfer(1'b0, 2'h1, cache_port_pkg::beat_code_t'(i));
            chk("cacheable", !i[0], cmd.cacheable);
            chk("ctrl space", !i[0], cmd.ctrl_space);
            chk("privileged", !i[0], cmd.privileged);
            chk("ack code", 3'h6 - i[2:0], last_ack);
            chk("size", i[1:0], cmd.size);
        end
        k0 = nwr;
        xfer(1'b1, 2'h1, cache_port_pkg::BC_DONE);
        chk("write acks", 1, nwr - k0);
        chk("pending", 0, wo_n);
        wdone = 1'b1;
        tick(1);
        wdone = 1'b0;
        tick(2);
        chk("pending done", 1, wo_n);
        xfer(1'b1, 2'h1, cache_port_pkg::BC_DONE);
        perr_n = 1'b0;
        tick(2);
        chk("proc error", 0, err_n);
        perr_n = 1'b1;
        tick(2);
        chk("pending cleared", 1, wo_n);
        ierr = 1'b1;
        tick(2);
        chk("internal error", 0, err_n);
        ierr = 1'b0;
        tick(2);
        chk("no error", 1, err_n);
        for (int k = 0; k < 16; k++) begin
            irqp = (k == 0) ? 15'h0 : ((15'h1 << (k - 1)) | 15'h1);
            tick(2);
            chk("irq level", k, irl);
        end
        iv = 1'b1;
        for (int k = 0; k < 10 && ir !== 1'b1; k++) tick(1);
        chk("launch strobe", 0, so_n);
        chk("launch oe", 1, soe);
        chk("launch wr", 0, swr_n);
        chk("launch addr", 36'h0_0000_0040, lad);
        chk("launch demap", 1, dmo_n);
        chk("grant withdrawn", 1, rg_n);
        iv = 1'b0;
        sr_n = 1'b0;
        tick(2);
        chk("reset out", 0, prst_n);
        sr_n = 1'b1;
        tick(2);
        chk("reset out off", 1, prst_n);
        wrap_up();
    end
endmodule : tb_top
